// ---- hdl/rf_channel_redundancy_ctrl.sv ----
/*
 RF channel integrity control: Wishbone register slave, parity insert and
 check, CRC append on transmit, CRC check on receive, stripped when it matches, test mux.
 Assumes a half-duplex link: transmit, receive and compute command never
 use the shared CRC engine in the same frame. One clock, mclk.
*/
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`include "rf_integrity_cfg.svh"
module rf_channel_redundancy_ctrl
   import rf_integrity_pkg::*;
(
   input  logic        mclk,
   input  logic        rst_n,
   input  logic [7:0]  adr_i,
   input  logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input  logic        we_i,
   input  logic [3:0]  sel_i,
   input  logic        cyc_i,
   input  logic        stb_i,
   output logic        ack_o,
   input  logic        txStart,
   input  logic        txInValid,
   input  tx_in_type   txIn,
   output logic        txOutValid,
   output tx_out_type  txOut,
   input  logic        rxStart,
   input  logic        rxInValid,
   input  rx_in_type   rxIn,
   output logic        fifoValid,
   output logic [7:0]  fifoData,
   input  logic        calcStart,
   input  logic        calcValid,
   input  logic [7:0]  calcData,
   input  logic        coderEnvelope,
   input  logic        serialData,
   input  logic        carrierDemod,
   input  logic        subcarrierDemod,
   output logic        testOutputPin
);

   logic [7:0]   integrityCfg;
   logic [7:0]   seedLow;
   logic [7:0]   seedHigh;
   logic [7:0]   fixedPreset;
   logic [7:0]   testSel;
   logic         crc_error_flag;
   logic         parityErr;
   logic [31:0]  next_readData;
   logic         busReq;
   logic         busWrite;
   logic [5:0]   regIdx;
   logic         altSel;
   logic         shortSel;
   logic         rx_crc_check_enable;
   logic         tx_crc_append_enable;
   logic         parity_polarity_select;
   logic         parity_insert_enable;
   tx_state_type txState;
   rx_state_type rxState;
   logic [1:0]   crcLen;
   logic [1:0]   heldCount;
   logic [7:0]   held0;
   logic [7:0]   held1;
   logic [7:0]   rxOldest;
   logic [15:0]  recvCrc;
   logic         crcMatch;
   logic         rxShift;
   logic         rxPush;
   logic         txFeed;
   logic         seedLoad;
   logic         engFeed;
   logic [7:0]   engByte;
   logic [15:0]  crcValue;
   logic         crcErrSet;
   logic         parityErrSet;

   ////////////////////////////////////////////////////////////////////////
   // configuration fields
   assign altSel    = integrityCfg[`CFG_ALT_BIT];
   assign shortSel  = integrityCfg[`CFG_SHORT_BIT];
   assign rx_crc_check_enable   = integrityCfg[`CFG_RXCRC_BIT];
   assign tx_crc_append_enable   = integrityCfg[`CFG_TXCRC_BIT];
   assign parity_polarity_select = integrityCfg[`CFG_ODD_BIT];
   assign parity_insert_enable  = integrityCfg[`CFG_PARITY_BIT];

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after the request, writes on the ack edge
   assign busReq   = cyc_i & stb_i;
   assign busWrite = busReq & ack_o & we_i & sel_i[0];
   assign regIdx   = adr_i[7:2];

   // ack drops the cycle after it is given, so each access is two cycles
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= busReq & ~ack_o;
      end
   end

   // read data decode, unmapped indexes read as zero
   always_comb begin
      if (regIdx == `IDX_INTEGRITY_CFG) begin
         next_readData = {24'h00_0000, integrityCfg};
      end else if (regIdx == `IDX_SEED_LOW) begin
         next_readData = {24'h00_0000, seedLow};
      end else if (regIdx == `IDX_SEED_HIGH) begin
         next_readData = {24'h00_0000, seedHigh};
      end else if (regIdx == `IDX_FIXED_PRESET) begin
         next_readData = {24'h00_0000, fixedPreset};
      end else if (regIdx == `IDX_TEST_SELECT) begin
         next_readData = {24'h00_0000, testSel};
      end else if (regIdx == `IDX_STATUS) begin
         next_readData = {8'h00, crcValue, 6'b00_0000, parityErr, crc_error_flag};
      end else begin
         next_readData = 32'h0000_0000;
      end
   end

   // read data is captured with the ack so it stands while ack is high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dat_o <= 32'h0000_0000;
      end else if (busReq & ~ack_o) begin
         dat_o <= next_readData;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         integrityCfg <= `RST_INTEGRITY_CFG;
         seedLow      <= `RST_SEED_LOW;
         seedHigh     <= `RST_SEED_HIGH;
         fixedPreset  <= `RST_FIXED_PRESET;
         testSel      <= `RST_TEST_SELECT;
      end else if (busWrite) begin
         if (regIdx == `IDX_INTEGRITY_CFG) begin
            integrityCfg <= dat_i[7:0];
         end else if (regIdx == `IDX_SEED_LOW) begin
            seedLow <= dat_i[7:0];
         end else if (regIdx == `IDX_SEED_HIGH) begin
            seedHigh <= dat_i[7:0];
         end else if (regIdx == `IDX_FIXED_PRESET) begin
            fixedPreset <= dat_i[7:0];
         end else if (regIdx == `IDX_TEST_SELECT) begin
            testSel <= dat_i[7:0];
         end
      end
   end

   // sticky flags, a new event wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         crc_error_flag    <= 1'b0;
         parityErr <= 1'b0;
      end else begin
         crc_error_flag <= crcErrSet | (crc_error_flag & ~(busWrite & (regIdx == `IDX_STATUS)
                                           & dat_i[`STS_CRC_ERROR_FLAG_BIT]));
         parityErr <= parityErrSet | (parityErr & ~(busWrite & (regIdx == `IDX_STATUS)
                                                    & dat_i[`STS_PARERR_BIT]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared crc engine
   // seed at every start when enabled
   assign seedLoad = (txStart & tx_crc_append_enable) | (rxStart & rx_crc_check_enable) | calcStart;
   assign txFeed   = txInValid & tx_crc_append_enable & (txState == TX_DATA);
   assign engFeed  = txFeed | rxShift | calcValid;
   assign engByte  = txFeed ? txIn.data : (rxShift ? rxOldest : calcData);

   crc_engine u_crc (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .seedLoad  (seedLoad),
      .seed      ({seedHigh, seedLow}),
      .byteValid (engFeed),
      .byteIn    (engByte),
      .shortSel  (shortSel),
      .altSel    (altSel),
      .crcValue  (crcValue)
   );

   ////////////////////////////////////////////////////////////////////////
   // transmit: parity per byte, crc bytes low first after the last data byte
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txState    <= TX_DATA;
         txOutValid <= 1'b0;
         txOut      <= '0;
      end else begin
         txOutValid <= 1'b0;
         case (txState)
            TX_DATA: begin
               if (txInValid) begin
                  txOut.data     <= txIn.data;
                  txOut.parity   <= parityBit(txIn.data, parity_polarity_select) & parity_insert_enable;
                  txOut.parityOn <= parity_insert_enable;
                  txOut.last     <= txIn.last & ~tx_crc_append_enable;
                  txOutValid     <= 1'b1;
                  if (txIn.last & tx_crc_append_enable) begin
                     txState <= TX_CRC_LO;
                  end
               end
            end
            TX_CRC_LO: begin
               txOut.data     <= crcValue[7:0];
               txOut.parity   <= parityBit(crcValue[7:0], parity_polarity_select) & parity_insert_enable;
               txOut.parityOn <= parity_insert_enable;
               txOut.last     <= shortSel;
               txOutValid     <= 1'b1;
               txState        <= shortSel ? TX_DATA : TX_CRC_HI;
            end
            TX_CRC_HI: begin
               txOut.data     <= crcValue[15:8];
               txOut.parity   <= parityBit(crcValue[15:8], parity_polarity_select) & parity_insert_enable;
               txOut.parityOn <= parity_insert_enable;
               txOut.last     <= 1'b1;
               txOutValid     <= 1'b1;
               txState        <= TX_DATA;
            end
            default: txState <= TX_DATA;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive: the last crcLen bytes are held back until the frame ends
   assign crcLen   = !rx_crc_check_enable ? 2'd0 : (shortSel ? 2'd1 : 2'd2);
   assign rxOldest = (heldCount == 2'd2) ? held1 : held0;
   assign rxPush   = rxInValid & (rxState == RX_RUN) & (crcLen != 2'd0);
   assign rxShift  = rxPush & (heldCount == crcLen);
   assign recvCrc  = shortSel ? {8'h00, held0} : {held0, held1};
   assign crcMatch = (heldCount == crcLen) & (recvCrc == crcValue);
   assign crcErrSet = (rxState == RX_CHECK) & ~crcMatch;
   assign parityErrSet = rxInValid & (rxState == RX_RUN) & parity_insert_enable
                         & (rxIn.parity != parityBit(rxIn.data, parity_polarity_select));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxState   <= RX_RUN;
         heldCount <= 2'd0;
         held0     <= 8'h00;
         held1     <= 8'h00;
         fifoValid <= 1'b0;
         fifoData  <= 8'h00;
      end else begin
         fifoValid <= 1'b0;
         case (rxState)
            RX_RUN: begin
               if (rxStart) begin
                  heldCount <= 2'd0;
               end else if (rxInValid & (crcLen == 2'd0)) begin
                  fifoValid <= 1'b1;
                  fifoData  <= rxIn.data;
               end else if (rxPush) begin
                  held1 <= held0;
                  held0 <= rxIn.data;
                  if (rxShift) begin
                     fifoValid <= 1'b1;
                     fifoData  <= rxOldest;
                  end else begin
                     heldCount <= heldCount + 2'd1;
                  end
                  if (rxIn.last) begin
                     rxState <= RX_CHECK;
                  end
               end
            end
            RX_CHECK: begin
               // mismatch flags and passes the bytes on
               if (crcMatch | (heldCount == 2'd0)) begin
                  heldCount <= 2'd0;
                  rxState   <= RX_RUN;
               end else begin
                  rxState <= RX_FLUSH;
               end
            end
            RX_FLUSH: begin
               fifoValid <= 1'b1;
               fifoData  <= rxOldest;
               heldCount <= heldCount - 2'd1;
               if (heldCount == 2'd1) begin
                  rxState <= RX_RUN;
               end
            end
            default: rxState <= RX_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // test output mux; reserved codes drive low as a safe default
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         testOutputPin <= 1'b0;
      end else begin
         case (testSel[2:0])
            `TSEL_LOW:      testOutputPin <= 1'b0;
            `TSEL_HIGH:     testOutputPin <= 1'b1;
            `TSEL_ENVELOPE: testOutputPin <= coderEnvelope;
            `TSEL_SERIAL:   testOutputPin <= serialData;
            `TSEL_CARRIER:  testOutputPin <= carrierDemod;
            `TSEL_SUBCARR:  testOutputPin <= subcarrierDemod;
            default:        testOutputPin <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   bus_ack_a : assert property (@(posedge mclk) disable iff (!rst_n)
      busReq && !ack_o |=> ack_o ##1 !ack_o)
      else $error("wishbone ack not one cycle");

   parity_gen_a : assert property (@(posedge mclk) disable iff (!rst_n)
      txOutValid && txOut.parityOn |->
         txOut.parity == ((^txOut.data) ^ $past(parity_polarity_select)))
      else $error("wrong transmit parity");

   parity_off_a : assert property (@(posedge mclk) disable iff (!rst_n)
      txOutValid |-> txOut.parityOn == $past(parity_insert_enable))
      else $error("parity insert mismatches enable");

   crc_append_a : assert property (@(posedge mclk) disable iff (!rst_n)
      txInValid && txIn.last && tx_crc_append_enable && txState == TX_DATA
         |=> txOutValid && !txOut.last ##1 txOutValid && txOut.data == $past(crcValue[7:0]))
      else $error("crc not appended");

   short_crc_a : assert property (@(posedge mclk) disable iff (!rst_n)
      txState == TX_CRC_LO && shortSel |=> txOut.last && txState == TX_DATA)
      else $error("short crc not one byte");

   check_after_a : assert property (@(posedge mclk) disable iff (!rst_n)
      rxPush && rxIn.last |=> rxState == RX_CHECK)
      else $error("check not after final byte");

   crc_error_a : assert property (@(posedge mclk) disable iff (!rst_n)
      rxState == RX_CHECK && !crcMatch |=> crc_error_flag && (rxState == RX_FLUSH || heldCount == 2'd0))
      else $error("crc mismatch not flagged");

   crc_withhold_a : assert property (@(posedge mclk) disable iff (!rst_n)
      rxState == RX_CHECK && crcMatch |=> !fifoValid && heldCount == 2'd0)
      else $error("good crc bytes passed on");

   test_static_a : assert property (@(posedge mclk) disable iff (!rst_n)
      testSel[2:1] == 2'b00 |=> testOutputPin == $past(testSel[0]))
      else $error("test output not static level");

   test_demod_a : assert property (@(posedge mclk) disable iff (!rst_n)
      testSel[2:0] == `TSEL_CARRIER |=> testOutputPin == $past(carrierDemod))
      else $error("carrier demod not routed");

endmodule // rf_channel_redundancy_ctrl

// ---- include/rf_integrity_cfg.svh ----
/*
 Offsets, field positions, reset values and coding constants of the
 RF channel integrity block.
 Assumes a 32-bit bus with word registers: byte address = 4 * index.
*/
`ifndef RF_INTEGRITY_CFG_SVH
`define RF_INTEGRITY_CFG_SVH

// register indexes, byte address is four times the index
`define IDX_INTEGRITY_CFG 6'h22
`define IDX_SEED_LOW      6'h23
`define IDX_SEED_HIGH     6'h24
`define IDX_FIXED_PRESET  6'h25
`define IDX_TEST_SELECT   6'h26
`define IDX_STATUS        6'h28

// reset values
`define RST_INTEGRITY_CFG 8'h03
`define RST_SEED_LOW      8'h63
`define RST_SEED_HIGH     8'h63
`define RST_FIXED_PRESET  8'h00
`define RST_TEST_SELECT   8'h00

// integrity config fields
`define CFG_ALT_BIT    5
`define CFG_SHORT_BIT  4
`define CFG_RXCRC_BIT  3
`define CFG_TXCRC_BIT  2
`define CFG_ODD_BIT    1
`define CFG_PARITY_BIT 0

// status fields (write one to clear the flags)
`define STS_CRC_ERROR_FLAG_BIT 0
`define STS_PARERR_BIT 1
`define STS_CRC_LSB    8

// test output selector codes
`define TSEL_LOW      3'h0
`define TSEL_HIGH     3'h1
`define TSEL_ENVELOPE 3'h2
`define TSEL_SERIAL   3'h3
`define TSEL_CARRIER  3'h4
`define TSEL_SUBCARR  3'h5

// reflected polynomials, shifted lsb first
`define CRC16_POLY 16'h8408
`define CRC_SHORT_SELECT_POLY  8'hB8

`endif

// ---- include/rf_integrity_pkg.sv ----
/*
 Types shared by the RF channel integrity block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rf_integrity_pkg;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } tx_in_type;

   typedef struct packed {
      logic [7:0] data;
      logic       parity;
      logic       parityOn;
      logic       last;
   } tx_out_type;

   typedef struct packed {
      logic [7:0] data;
      logic       parity;
      logic       last;
   } rx_in_type;

   typedef enum logic [2:0] {
      TX_DATA   = 3'b001,
      TX_CRC_LO = 3'b010,
      TX_CRC_HI = 3'b100
   } tx_state_type;

   typedef enum logic [2:0] {
      RX_RUN   = 3'b001,
      RX_CHECK = 3'b010,
      RX_FLUSH = 3'b100
   } rx_state_type;

   // parity bit for one byte; odd=1 makes the nine bits odd
   function automatic logic parityBit(input logic [7:0] data, input logic odd);
      return (^data) ^ odd;
   endfunction

endpackage

// ---- hdl/crc_engine.sv ----
/*
 Byte-wide CRC engine, 16-bit or 8-bit, lsb first.
 Assumes at most one of seed load or byte feed per cycle from its user.
*/
`timescale 1ns/10ps
`include "rf_integrity_cfg.svh"
module crc_engine (
   input  logic        mclk,
   input  logic        rst_n,
   input  logic        seedLoad,
   input  logic [15:0] seed,
   input  logic        byteValid,
   input  logic [7:0]  byteIn,
   input  logic        shortSel,
   input  logic        altSel,
   output logic [15:0] crcValue
);

   logic [15:0] crcRaw;

   ////////////////////////////////////////////////////////////////////////
   // one byte through the shift register, eight steps unrolled by the loop
   function automatic logic [15:0] crcStep(input logic [15:0] crc,
                                           input logic [7:0]  data,
                                           input logic        short);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         if (short) begin
            c = {8'h00, 1'b0, c[7:1]} ^ (c[0] ? {8'h00, `CRC_SHORT_SELECT_POLY} : 16'h0000);
         end else begin
            c = {1'b0, c[15:1]} ^ (c[0] ? `CRC16_POLY : 16'h0000);
         end
      end
      return c;
   endfunction

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         crcRaw <= 16'h0000;
      end else if (seedLoad) begin
         crcRaw <= shortSel ? {8'h00, seed[7:0]} : seed;
      end else if (byteValid) begin
         crcRaw <= crcStep(crcRaw, byteIn, shortSel);
      end
   end

   // short result keeps the low byte only
   assign crcValue = shortSel ? {8'h00, crcRaw[7:0] ^ {8{altSel}}}
                              : crcRaw ^ {16{altSel}};

   seed_load_a : assert property (@(posedge mclk) disable iff (!rst_n)
      seedLoad && !shortSel |=> crcRaw == $past(seed))
      else $error("seed not loaded into crc");

   seed_short_a : assert property (@(posedge mclk) disable iff (!rst_n)
      seedLoad && shortSel |=> crcRaw == {8'h00, $past(seed[7:0])})
      else $error("short crc took high seed byte");

endmodule // crc_engine

// ---- verification/card_model.sv ----
/*
 Behavioural contactless card on the far side of the RF channel.
 Assumes the bench calls sendFrame and reads the heard queue.
*/
`timescale 1ns/10ps
module card_model
   import rf_integrity_pkg::*;
(
   input  logic       mclk,
   input  logic       txOutValid,
   input  tx_out_type txOut,
   output logic       rxStart,
   output logic       rxInValid,
   output rx_in_type  rxIn
);
   tx_out_type heard[$];

   // quiet link until the bench asks for a frame
   initial begin
      rxStart = 1'b0;
      rxInValid = 1'b0;
      rxIn = '0;
   end

   // every byte the reader puts on the air
   always @(posedge mclk) begin
      if (txOutValid === 1'b1) begin
         heard.push_back(txOut);
      end
   end

   // one frame back, gap idle cycles between bytes; idle data toggles so a
   // stale byte is never mistaken for a fresh one
   task automatic sendFrame(input logic [7:0] b[$], input logic odd, input int gap);
      @(posedge mclk);
      rxStart <= 1'b1;
      @(posedge mclk);
      rxStart <= 1'b0;
      foreach (b[i]) begin
         rxInValid <= 1'b1;
         rxIn <= '{data: b[i], parity: (^b[i]) ^ odd, last: (i == b.size() - 1)};
         @(posedge mclk);
         // back to back bytes keep valid up rather than drop and raise it in one step
         if (gap > 0 || i == b.size() - 1) begin
            rxInValid <= 1'b0;
            rxIn <= ~rxIn;
            repeat (gap) @(posedge mclk);
         end
      end
   endtask
endmodule // card_model

// ---- verification/tb_top.sv ----
/*
 Self-checking bench: Wishbone register access, transmit, receive,
 compute and test output scenarios.
 Assumes card_model and the design are compiled first.
*/
`timescale 1ns/10ps
module tb_top
   import rf_integrity_pkg::*;
;
   localparam logic [7:0] SEED_LO = 8'h12;
   localparam logic [7:0] SEED_HI = 8'h34;
   logic        mclk, rst_n, we, cyc, stb, ack, pin;
   logic        txStart, txInValid, txOutValid, rxStart, rxInValid, fifoValid;
   logic        calcStart, calcValid;
   logic [7:0]  adr, fifoData, calcData;
   logic [31:0] wdat, rdat, s;
   logic [3:0]  sel, taps;
   tx_in_type   txIn;
   tx_out_type  txOut;
   rx_in_type   rxIn;
   logic [7:0]  frame[$], fifoGot[$];
   int          nMismatch, checked, cycles;

   rf_channel_redundancy_ctrl rf_channel_redundancy_ctrl_i (.mclk(mclk), .rst_n(rst_n),
      .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc),
      .stb_i(stb), .ack_o(ack), .txStart(txStart), .txInValid(txInValid), .txIn(txIn),
      .txOutValid(txOutValid), .txOut(txOut), .rxStart(rxStart), .rxInValid(rxInValid),
      .rxIn(rxIn), .fifoValid(fifoValid), .fifoData(fifoData), .calcStart(calcStart),
      .calcValid(calcValid), .calcData(calcData), .coderEnvelope(taps[3]),
      .serialData(taps[2]), .carrierDemod(taps[1]), .subcarrierDemod(taps[0]),
      .testOutputPin(pin));
   card_model card_model_i (.mclk(mclk), .txOutValid(txOutValid), .txOut(txOut),
      .rxStart(rxStart), .rxInValid(rxInValid), .rxIn(rxIn));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         nMismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      check(q, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   // reflected crc, lsb first; short mode keeps only the low seed byte
   function automatic logic [15:0] crcOf(input logic [7:0] b[$], input logic [7:0] cfg);
      logic [15:0] c;
      logic        fb;
      c = cfg[4] ? {8'h00, SEED_LO} : {SEED_HI, SEED_LO};
      foreach (b[i]) for (int k = 0; k < 8; k++) begin
         fb = c[0] ^ b[i][k];
         c = c >> 1;
         if (fb) c = c ^ (cfg[4] ? 16'h00B8 : 16'h8408);
      end
      if (cfg[5]) c = cfg[4] ? {8'h00, ~c[7:0]} : ~c;
      return c;
   endfunction

   // send two bytes back to back and compare the whole air stream
   task automatic txFrame(input logic [7:0] cfg);
      logic [15:0] c;
      logic [7:0]  b;
      int          nc;
      c = crcOf(frame, cfg);
      nc = cfg[2] ? (cfg[4] ? 1 : 2) : 0;
      card_model_i.heard.delete();
      wr(8'h88, {24'h00_0000, cfg});
      txStart <= 1'b1;
      @(posedge mclk);
      txStart <= 1'b0;
      foreach (frame[i]) begin
         txInValid <= 1'b1;
         txIn <= '{data: frame[i], last: (i == 1)};
         @(posedge mclk);
      end
      txInValid <= 1'b0;
      repeat (6) @(posedge mclk);
      check(card_model_i.heard.size(), 2 + nc);
      for (int i = 0; i < 2 + nc; i++) begin
         b = (i < 2) ? frame[i] : (i == 2 ? c[7:0] : c[15:8]);
         check(card_model_i.heard[i], {b, cfg[0] & (^b ^ cfg[1]), cfg[0], i == 1 + nc});
      end
   endtask

   // card answers with a good or spoiled crc; fifo and flags compared
   task automatic rxFrame(input logic [7:0] cfg, input logic bad, input int gap);
      logic [7:0]  d[$];
      logic [15:0] c;
      int          nd;
      d = frame;
      c = crcOf(frame, cfg);
      wr(8'h88, {24'h00_0000, cfg});
      d.push_back(c[7:0]);
      if (!cfg[4]) d.push_back(c[15:8]);
      d[d.size() - 1] ^= {7'h00, bad};
      fifoGot.delete();
      card_model_i.sendFrame(d, cfg[1], gap);
      repeat (6) @(posedge mclk);
      nd = (cfg[3] && !bad) ? 2 : d.size();
      check(fifoGot.size(), nd);
      for (int i = 0; i < nd; i++) check(fifoGot[i], d[i]);
      wb(1'b0, 8'hA0, 32'h0000_0000, s);
      check(s[1:0], {1'b0, cfg[3] & bad});
      wr(8'hA0, 32'h0000_0003);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // free-running clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 5000) begin
         nMismatch++;
         report_and_stop();
      end
   end
   // bytes handed to the fifo
   always @(posedge mclk) begin
      if (fifoValid === 1'b1) fifoGot.push_back(fifoData);
   end

   initial begin
      {rst_n, we, cyc, stb, txStart, txInValid, rxStart, calcStart, calcValid} = '0;
      {adr, wdat, calcData, txIn, taps} = '0;
      sel = 4'h1;
      frame = '{8'hA5, 8'h3C};
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      rd(8'h88, 32'h0000_0003);
      rd(8'h8C, 32'h0000_0063);
      rd(8'h90, 32'h0000_0063);
      rd(8'h94, 32'h0000_0000);
      wr(8'hFC, 32'h0000_0055);
      rd(8'hFC, 32'h0000_0000);
      wr(8'h8C, {24'h00_0000, SEED_LO});
      wr(8'h90, {24'h00_0000, SEED_HI});
      rd(8'h8C, {24'h00_0000, SEED_LO});
      $display("test registers done");
      // odd and even parity, long and short crc, plain and inverted result
      txFrame(8'h07);
      txFrame(8'h17);
      txFrame(8'h25);
      txFrame(8'h35);
      txFrame(8'h02);
      txFrame(8'h03);
      $display("test transmit done");
      rxFrame(8'h0B, 1'b0, 0);
      rxFrame(8'h0B, 1'b1, 2);
      rxFrame(8'h1B, 1'b0, 1);
      rxFrame(8'h2B, 1'b1, 0);
      rxFrame(8'h1B, 1'b1, 0);
      rxFrame(8'h03, 1'b0, 0);
      // card answers with the wrong parity polarity; only the parity flag rises
      card_model_i.sendFrame(frame, 1'b0, 0);
      repeat (6) @(posedge mclk);
      wb(1'b0, 8'hA0, 32'h0000_0000, s);
      check(s[1:0], 2'b10);
      wr(8'hA0, 32'h0000_0003);
      $display("test receive done");
      wr(8'h88, 32'h0000_0003);
      calcStart <= 1'b1;
      @(posedge mclk);
      calcStart <= 1'b0;
      calcValid <= 1'b1;
      calcData <= frame[0];
      @(posedge mclk);
      calcData <= frame[1];
      @(posedge mclk);
      calcValid <= 1'b0;
      repeat (3) @(posedge mclk);
      wb(1'b0, 8'hA0, 32'h0000_0000, s);
      check(s[23:8], crcOf(frame, 8'h03));
      $display("test compute done");
      // demodulator taps exercised as plain levels only
      // reserved codes 110 and 111 are never programmed
      for (int p = 0; p < 2; p++) for (int k = 0; k < 6; k++) begin
         taps <= p ? 4'b0101 : 4'b1010;
         wr(8'h98, 32'(k));
         repeat (2) @(posedge mclk);
         check(pin, k == 1 ? 1'b1 : (k >= 2 && k <= 5) ? taps[5 - k] : 1'b0);
      end
      $display("test output select done");
      report_and_stop();
   end
endmodule // tb_top
